// ===== cssio_pkg.sv
package cssio_pkg;
  // register byte offsets
  localparam logic [7:0] CSSIO_CTRL_OFF = 8'h00;
  localparam logic [7:0] CSSIO_STAT_OFF = 8'h04;
  localparam logic [7:0] CSSIO_TXD_OFF = 8'h08;
  localparam logic [7:0] CSSIO_RXD_OFF = 8'h0C;
  localparam logic [7:0] CSSIO_IEN_OFF = 8'h10;
  localparam logic [7:0] CSSIO_ICLR_OFF = 8'h14;
  localparam logic [7:0] CSSIO_DIV_OFF = 8'h18;
  // control fields
  localparam int CSSIO_C_TXEN = 0;
  localparam int CSSIO_C_RXEN = 1;
  localparam int CSSIO_C_EXTCLK = 2;
  localparam int CSSIO_C_EDGE = 3;
  localparam int CSSIO_C_RTSEN = 4;
  localparam int CSSIO_C_CTSEN = 5;
  localparam int CSSIO_C_CUT = 6;
  localparam logic [6:0] CSSIO_CTRL_RST = 7'h00;
  // status fields: sticky events in bits 0..2 share the enable and clear layout
  localparam int CSSIO_S_TXEMPTY = 3;
  localparam int CSSIO_S_RXFULL = 4;
  localparam int CSSIO_S_OVR = 2;
  localparam int CSSIO_S_DONE = 1;
  localparam int CSSIO_NIRQ = 3;
  localparam logic [15:0] CSSIO_DIV_RST = 16'h0004;
  localparam int CSSIO_BITS = 8;
  typedef enum logic [2:0] {
    CSSIO_IDLE = 3'b001,
    CSSIO_SHIFT = 3'b010,
    CSSIO_LAST = 3'b100
  } cssio_state_t;
endpackage : cssio_pkg

// ===== cssio_sync.sv
`timescale 1ns/1ns
`default_nettype none
module cssio_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // level
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : cssio_sync
`default_nettype wire

// ===== cssio_core.sv
// Contract
// - external clock flow control: ready output low
// - ready output returns high on reception start
// - internal clock: ready output has no effect
// - cutoff enabled and shutdown low: tristate data, ready and third clock pins; shift clock pin stays driven
// - start needs enable, data held, permit low when permit input enabled
// - edge select chooses shift and sample edges
// - transmitter makes clock; dummy data driven out
// - internal clock: enable plus write starts clock
// - external clock: shifting follows partner pulses
// - frame while receive full sets overrun
// - overrun leaves receive request flag untouched
`timescale 1ns/1ns
`default_nettype none
module cssio_core
  import cssio_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial pins
  input wire logic shift_clock_pin_i,
  output logic shift_clock_pin_o,
  output logic shift_clock_pin_oe,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic serial_in,
  output logic ready_to_accept_out,
  output logic ready_to_accept_oe,
  input wire logic send_permit_in,
  output logic third_shift_clock_pin_o,
  output logic third_shift_clock_pin_oe,
  input wire logic shutdown_in,
  // interrupt
  output logic irq
);
  import cssio_pkg::*;

  logic [6:0] ctrl_q;
  logic [15:0] div_q;
  logic [7:0] tx_holding_q;
  logic [7:0] rx_holding_q;
  logic transmit_buffer_empty_q;
  logic rx_full_q;
  logic [CSSIO_NIRQ-1:0] stat_q;
  logic [CSSIO_NIRQ-1:0] ien_q;
  cssio_state_t state_q;
  logic [7:0] tx_sh_q;
  logic [7:0] rx_sh_q;
  logic [3:0] cnt_q;
  logic [15:0] div_cnt_q;
  logic int_clk_q;
  logic out_bit_q;
  logic sclk_s;
  logic sdin_s;
  logic cts_s;
  logic sd_s;
  logic sclk_prev_q;

  logic transmit_enable;
  logic rx_on;
  logic ext_clk;
  logic clock_edge_select;
  logic cutoff_enable;
  assign transmit_enable = ctrl_q[CSSIO_C_TXEN];
  assign rx_on = ctrl_q[CSSIO_C_RXEN];
  assign ext_clk = ctrl_q[CSSIO_C_EXTCLK];
  assign clock_edge_select = ctrl_q[CSSIO_C_EDGE];
  assign cutoff_enable = ctrl_q[CSSIO_C_CUT];

  // pins cross into sys_clk before use
  cssio_sync #(.RST_VAL(1'b1)) u_sync_clk (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(shift_clock_pin_i), .sync_out(sclk_s));
  cssio_sync #(.RST_VAL(1'b1)) u_sync_din (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(serial_in), .sync_out(sdin_s));
  cssio_sync #(.RST_VAL(1'b1)) u_sync_cts (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(send_permit_in), .sync_out(cts_s));
  cssio_sync #(.RST_VAL(1'b1)) u_sync_sd (.sys_clk(sys_clk), .arst_n(arst_n),
    .async_in(shutdown_in), .sync_out(sd_s));

  // ---------------- bus slave ----------------
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic rd_fire;
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_got_q && w_got_q;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == CSSIO_CTRL_OFF || awaddr_q == CSSIO_TXD_OFF ||
            awaddr_q == CSSIO_IEN_OFF || awaddr_q == CSSIO_ICLR_OFF ||
            awaddr_q == CSSIO_DIV_OFF) begin
          s_axi_bresp <= 2'b00;
        end else begin
          s_axi_bresp <= 2'b10;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_ctrl;
  logic wr_txd;
  logic wr_ien;
  logic wr_iclr;
  logic wr_div;
  assign wr_ctrl = wr_fire && awaddr_q == CSSIO_CTRL_OFF && wstrb_q[0];
  assign wr_txd = wr_fire && awaddr_q == CSSIO_TXD_OFF && wstrb_q[0];
  assign wr_ien = wr_fire && awaddr_q == CSSIO_IEN_OFF && wstrb_q[0];
  assign wr_iclr = wr_fire && awaddr_q == CSSIO_ICLR_OFF && wstrb_q[0];
  assign wr_div = wr_fire && awaddr_q == CSSIO_DIV_OFF;
  logic rd_rxd;
  assign rd_rxd = rd_fire && s_axi_araddr == CSSIO_RXD_OFF;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (s_axi_araddr == CSSIO_CTRL_OFF) begin
        s_axi_rdata <= {25'h0, ctrl_q};
      end else if (s_axi_araddr == CSSIO_STAT_OFF) begin
        s_axi_rdata <= {27'h0, rx_full_q, transmit_buffer_empty_q, stat_q};
      end else if (s_axi_araddr == CSSIO_TXD_OFF) begin
        s_axi_rdata <= {24'h0, tx_holding_q};
      end else if (s_axi_araddr == CSSIO_RXD_OFF) begin
        s_axi_rdata <= {24'h0, rx_holding_q};
      end else if (s_axi_araddr == CSSIO_IEN_OFF) begin
        s_axi_rdata <= {29'h0, ien_q};
      end else if (s_axi_araddr == CSSIO_DIV_OFF) begin
        s_axi_rdata <= {16'h0, div_q};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b10;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= CSSIO_CTRL_RST;
      ien_q <= '0;
      div_q <= CSSIO_DIV_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= wdata_q[6:0];
      if (wr_ien) ien_q <= wdata_q[CSSIO_NIRQ-1:0];
      if (wr_div) div_q <= (wdata_q[15:0] == 16'h0000) ? 16'h0001 : wdata_q[15:0];
    end
  end

  // ---------------- shift engine ----------------
  logic start_ok;
  logic load;
  logic idle_lvl;
  logic lead_edge;
  logic trail_edge;
  logic int_tick;
  logic frame_done;
  logic ext_rise;
  logic ext_fall;
  logic cur_clk;
  // idle clock level is high for edge select 0, low for 1
  assign idle_lvl = !clock_edge_select;
  assign start_ok = transmit_enable && !transmit_buffer_empty_q &&
                    (!ctrl_q[CSSIO_C_CTSEN] || !cts_s);
  assign load = (state_q == CSSIO_IDLE) && start_ok;
  assign ext_rise = sclk_s && !sclk_prev_q;
  assign ext_fall = !sclk_s && sclk_prev_q;
  assign int_tick = (state_q != CSSIO_IDLE) && !ext_clk && (div_cnt_q == 16'h0001);
  // leading edge moves away from idle level (shift out), trailing returns (sample)
  assign cur_clk = ext_clk ? sclk_s : int_clk_q;
  assign lead_edge = ext_clk ? (clock_edge_select ? ext_rise : ext_fall)
                             : (int_tick && int_clk_q == idle_lvl);
  assign trail_edge = ext_clk ? (clock_edge_select ? ext_fall : ext_rise)
                              : (int_tick && int_clk_q != idle_lvl);
  assign frame_done = (state_q == CSSIO_LAST) && trail_edge;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  // divider runs only inside a frame; one edge per half period
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt_q <= CSSIO_DIV_RST;
      int_clk_q <= 1'b1;
    end else if (state_q == CSSIO_IDLE || ext_clk) begin
      div_cnt_q <= div_q;
      int_clk_q <= idle_lvl;
    end else if (int_tick) begin
      div_cnt_q <= div_q;
      int_clk_q <= !int_clk_q;
    end else begin
      div_cnt_q <= div_cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= CSSIO_IDLE;
      tx_sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      cnt_q <= 4'h0;
      out_bit_q <= 1'b1;
    end else begin
      case (state_q)
        CSSIO_IDLE: begin
          if (load) begin
            tx_sh_q <= tx_holding_q;
            cnt_q <= 4'h0;
            state_q <= CSSIO_SHIFT;
          end
        end
        CSSIO_SHIFT: begin
          if (lead_edge) begin
            out_bit_q <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[7:1]};
          end
          if (trail_edge) begin
            rx_sh_q <= {sdin_s, rx_sh_q[7:1]};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'(CSSIO_BITS - 2)) state_q <= CSSIO_LAST;
          end
        end
        CSSIO_LAST: begin
          if (lead_edge) begin
            out_bit_q <= tx_sh_q[0];
          end
          if (trail_edge) begin
            rx_sh_q <= {sdin_s, rx_sh_q[7:1]};
            state_q <= CSSIO_IDLE;
          end
        end
        default: state_q <= CSSIO_IDLE;
      endcase
    end
  end

  // ---------------- holding registers and flags ----------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_holding_q <= 8'h00;
      transmit_buffer_empty_q <= 1'b1;
    end else begin
      if (wr_txd) tx_holding_q <= wdata_q[7:0];
      if (load) begin
        transmit_buffer_empty_q <= 1'b1;
      end else if (wr_txd) begin
        transmit_buffer_empty_q <= 1'b0;
      end
    end
  end

  logic overrun_ev;
  logic rx_ev;
  assign overrun_ev = frame_done && rx_on && rx_full_q && !rd_rxd;
  assign rx_ev = frame_done && rx_on && !(rx_full_q && !rd_rxd);

  // overrun leaves rx_holding unloaded, its content treated as undefined
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_holding_q <= 8'h00;
      rx_full_q <= 1'b0;
    end else begin
      if (rx_ev) begin
        rx_holding_q <= {sdin_s, rx_sh_q[7:1]};
        rx_full_q <= 1'b1;
      end else if (rd_rxd) begin
        rx_full_q <= 1'b0;
      end
    end
  end

  // sticky status: set beats clear
  logic [CSSIO_NIRQ-1:0] set_v;
  logic [CSSIO_NIRQ-1:0] clr_v;
  assign set_v = {overrun_ev, rx_ev, load};
  assign clr_v = wr_iclr ? wdata_q[CSSIO_NIRQ-1:0] : '0;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= '0;
    end else begin
      stat_q <= set_v | (stat_q & ~clr_v);
    end
  end
  assign irq = |(stat_q & ien_q);

  // ---------------- pins ----------------
  logic cut;
  logic ready_lvl;
  logic rx_started_q;
  assign cut = cutoff_enable && !sd_s;
  // first clock edge of an armed frame marks the start of reception
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_started_q <= 1'b0;
    end else if (load) begin
      rx_started_q <= 1'b0;
    end else if (lead_edge && state_q != CSSIO_IDLE) begin
      rx_started_q <= 1'b1;
    end
  end
  // low only while armed with dummy data and no edge yet; idle without data cannot take a frame
  assign ready_lvl = !(rx_on && !rx_full_q && state_q != CSSIO_IDLE && !rx_started_q);
  assign ready_to_accept_out = (ext_clk && ctrl_q[CSSIO_C_RTSEN]) ? ready_lvl : 1'b1;
  assign ready_to_accept_oe = ctrl_q[CSSIO_C_RTSEN] && !cut;
  assign serial_out = out_bit_q;
  assign serial_out_oe = transmit_enable && !cut;
  assign shift_clock_pin_o = int_clk_q;
  assign shift_clock_pin_oe = !ext_clk;
  assign third_shift_clock_pin_o = cur_clk;
  assign third_shift_clock_pin_oe = !ext_clk && !cut;

  // ---------------- assertions ----------------
  sequence s_loaded;
    load;
  endsequence
  sequence s_empty_next;
    ##1 transmit_buffer_empty_q && state_q == CSSIO_SHIFT;
  endsequence
  property p_load_empties;
    @(posedge sys_clk) disable iff (!arst_n) s_loaded |-> s_empty_next;
  endproperty
  a_load_empties: assert property (p_load_empties) else $error("load not empty");

  property p_start_needs_enable;
    @(posedge sys_clk) disable iff (!arst_n)
      $rose(state_q == CSSIO_SHIFT) |-> $past(transmit_enable) && !$past(transmit_buffer_empty_q);
  endproperty
  a_start_needs_enable: assert property (p_start_needs_enable) else $error("bad start");

  property p_cts_blocks;
    @(posedge sys_clk) disable iff (!arst_n)
      (state_q == CSSIO_IDLE && ctrl_q[CSSIO_C_CTSEN] && cts_s) |=> state_q == CSSIO_IDLE;
  endproperty
  a_cts_blocks: assert property (p_cts_blocks) else $error("start without permit");

  property p_cut_hiz;
    @(posedge sys_clk) disable iff (!arst_n)
      (cutoff_enable && !sd_s) |-> !serial_out_oe && !third_shift_clock_pin_oe && !ready_to_accept_oe;
  endproperty
  a_cut_hiz: assert property (p_cut_hiz) else $error("pins driven in cutoff");

  property p_overrun;
    @(posedge sys_clk) disable iff (!arst_n)
      (frame_done && rx_on && rx_full_q && !rd_rxd) |=> stat_q[CSSIO_S_OVR] && $stable(rx_holding_q);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");

  property p_overrun_no_req;
    @(posedge sys_clk) disable iff (!arst_n)
      overrun_ev |-> !rx_ev ##1 !$rose(stat_q[CSSIO_S_DONE]);
  endproperty
  a_overrun_no_req: assert property (p_overrun_no_req) else $error("rx req on overrun");

  property p_rts_busy;
    @(posedge sys_clk) disable iff (!arst_n)
      (ext_clk && ctrl_q[CSSIO_C_RTSEN] && state_q != CSSIO_IDLE && lead_edge)
        |=> ready_to_accept_out;
  endproperty
  a_rts_busy: assert property (p_rts_busy) else $error("ready low in frame");

  property p_rts_ready;
    @(posedge sys_clk) disable iff (!arst_n)
      (ext_clk && ctrl_q[CSSIO_C_RTSEN] && rx_on && !rx_full_q && state_q != CSSIO_IDLE &&
       !rx_started_q)
        |-> !ready_to_accept_out;
  endproperty
  a_rts_ready: assert property (p_rts_ready) else $error("ready not low");

  property p_rts_internal;
    @(posedge sys_clk) disable iff (!arst_n) !ext_clk |-> ready_to_accept_out;
  endproperty
  a_rts_internal: assert property (p_rts_internal) else $error("ready moved, internal");

  property p_ext_hold;
    @(posedge sys_clk) disable iff (!arst_n)
      (ext_clk && state_q == CSSIO_SHIFT && $stable(sclk_s)) |=> $stable(cnt_q);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("shift without clock");

  property p_int_idle_level;
    @(posedge sys_clk) disable iff (!arst_n)
      (!ext_clk && state_q == CSSIO_IDLE && $stable(ctrl_q)) |-> int_clk_q == idle_lvl;
  endproperty
  a_int_idle_level: assert property (p_int_idle_level) else $error("clock not parked");
endmodule : cssio_core
`default_nettype wire

// ===== cssio_partner.sv
`timescale 1ns/1ns
`default_nettype none
module cssio_partner (
  // line
  input wire logic edge_sel,
  input wire logic line_clk,
  input wire logic data_in,
  output logic clk_ext,
  output logic data_out
);
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  int bit_idx;
  int edge_count;
  initial begin
    clk_ext = 1'b1;
    data_out = 1'b0;
    tx_byte = 8'h00;
    rx_byte = 8'h00;
    bit_idx = 0;
    edge_count = 0;
  end
  // leading edge presents the next bit, trailing edge takes one, lsb first
  always @(line_clk) begin
    edge_count++;
    if (bit_idx < 8 && line_clk === edge_sel) begin
      data_out <= tx_byte[bit_idx];
    end else if (bit_idx < 8 && line_clk === ~edge_sel) begin
      rx_byte <= {data_in, rx_byte[7:1]};
      bit_idx++;
      // hold the last bit a while, then stop showing it
      if (bit_idx == 8) begin
        data_out <= #60 ~tx_byte[7];
      end
    end
  end
  task automatic arm(input logic [7:0] b);
    clk_ext = ~edge_sel;
    #1;
    tx_byte = b;
    bit_idx = 0;
    edge_count = 0;
  endtask : arm
  // 80 ns period, clock parked at the idle level outside the frame
  task automatic ext_frame();
    #3;
    repeat (8) begin
      #40 clk_ext = edge_sel;
      #40 clk_ext = ~edge_sel;
    end
  endtask : ext_frame
endmodule : cssio_partner
`default_nettype wire

// ===== clock_sync_serial_io_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module clock_sync_serial_io_tb_top;
  import cssio_pkg::*;
  logic sys_clk, arst_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic shift_clock_pin_o, shift_clock_pin_oe, serial_out, serial_out_oe, serial_in;
  logic ready_to_accept_out, ready_to_accept_oe, send_permit_in, shutdown_in, irq;
  logic third_shift_clock_pin_o, third_shift_clock_pin_oe, clk_ext, edge_sel;
  wire sck;
  wire sdo;
  int miscompares = 0;
  int check_count = 0;
  assign sck = shift_clock_pin_oe ? shift_clock_pin_o : clk_ext;
  // data line assumed pulled up while released
  assign sdo = serial_out_oe ? serial_out : 1'b1;
  cssio_core i_dut (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .shift_clock_pin_i(sck), .shift_clock_pin_o,
    .shift_clock_pin_oe, .serial_out, .serial_out_oe, .serial_in, .ready_to_accept_out,
    .ready_to_accept_oe, .send_permit_in, .third_shift_clock_pin_o,
    .third_shift_clock_pin_oe, .shutdown_in, .irq);
  cssio_partner i_partner (.edge_sel, .line_clk(sck), .data_in(sdo), .clk_ext,
    .data_out(serial_in));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  // ready is stable from the falling edge on, so it is looked at there
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw, b;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    do begin
      @(negedge sys_clk);
      ta = s_axi_awready & pa;
      tw = s_axi_wready & pw;
      @(posedge sys_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa & ~ta;
      pw = pw & ~tw;
    end while (pa | pw);
    do begin
      @(negedge sys_clk);
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge sys_clk);
    end while (!b);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic t;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge sys_clk);
      t = s_axi_arready;
      @(posedge sys_clk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge sys_clk);
      t = s_axi_rvalid;
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge sys_clk);
    end while (!t);
  endtask : rd
  task automatic wait_rx(input int b);
    for (int i = 0; i < 60; i++) begin
      rd(CSSIO_STAT_OFF);
      if (rdat[b]) break;
    end
  endtask : wait_rx
  task automatic drain();
    rd(CSSIO_RXD_OFF);
    wr(CSSIO_ICLR_OFF, 32'h7);
  endtask : drain
  task automatic t_reset();
    @(negedge sys_clk);
    chk({irq, serial_out, serial_out_oe}, 3'h2);
  endtask : t_reset
  // internal clock, flow-control output enabled yet without effect
  task automatic t_internal(input logic e);
    @(posedge sys_clk);
    edge_sel <= e;
    wr(CSSIO_CTRL_OFF, 32'h13 | (32'(e) << CSSIO_C_EDGE));
    i_partner.arm(8'h5A ^ {8{e}});
    wr(CSSIO_TXD_OFF, 32'hC3);
    @(negedge sys_clk);
    chk(third_shift_clock_pin_o, !e);
    chk(ready_to_accept_out, 1'b1);
    rd(CSSIO_STAT_OFF);
    chk(rdat[CSSIO_S_TXEMPTY], 1'b1);
    wait_rx(CSSIO_S_RXFULL);
    chk(i_partner.rx_byte, 8'hC3);
    rd(CSSIO_RXD_OFF);
    chk(rdat[7:0], 8'h5A ^ {8{e}});
    chk(rsp, 2'h0);
    wr(CSSIO_ICLR_OFF, 32'h7);
  endtask : t_internal
  task automatic t_start();
    i_partner.arm(8'h00);
    wr(CSSIO_CTRL_OFF, 32'h22);
    send_permit_in <= 1'b1;
    wr(CSSIO_TXD_OFF, 32'h11);
    repeat (100) @(posedge sys_clk);
    chk(i_partner.edge_count, 0);
    wr(CSSIO_CTRL_OFF, 32'h23);
    repeat (100) @(posedge sys_clk);
    chk(i_partner.edge_count, 0);
    send_permit_in <= 1'b0;
    wait_rx(CSSIO_S_RXFULL);
    chk(i_partner.rx_byte, 8'h11);
    drain();
  endtask : t_start
  task automatic t_external();
    wr(CSSIO_CTRL_OFF, 32'h17);
    i_partner.arm(8'h96);
    wr(CSSIO_TXD_OFF, 32'h69);
    @(negedge sys_clk);
    chk({ready_to_accept_out, ready_to_accept_oe}, 2'h1);
    repeat (50) @(posedge sys_clk);
    rd(CSSIO_STAT_OFF);
    chk(rdat[CSSIO_S_RXFULL], 1'b0);
    fork
      i_partner.ext_frame();
      begin
        repeat (20) @(negedge sys_clk);
        chk(ready_to_accept_out, 1'b1);
      end
    join
    wait_rx(CSSIO_S_RXFULL);
    chk(i_partner.rx_byte, 8'h69);
    rd(CSSIO_RXD_OFF);
    chk(rdat[7:0], 8'h96);
    wr(CSSIO_ICLR_OFF, 32'h7);
  endtask : t_external
  task automatic t_overrun();
    wr(CSSIO_IEN_OFF, 32'h4);
    wr(CSSIO_CTRL_OFF, 32'h03);
    i_partner.arm(8'h01);
    wr(CSSIO_TXD_OFF, 32'hFF);
    wait_rx(CSSIO_S_RXFULL);
    @(negedge sys_clk);
    chk(irq, 1'b0);
    wr(CSSIO_ICLR_OFF, 32'h2);
    i_partner.arm(8'h02);
    wr(CSSIO_TXD_OFF, 32'hFE);
    wait_rx(CSSIO_S_OVR);
    chk(rdat[CSSIO_S_OVR], 1'b1);
    chk(rdat[CSSIO_S_DONE], 1'b0);
    @(negedge sys_clk);
    chk(irq, 1'b1);
    wr(CSSIO_ICLR_OFF, 32'h4);
    @(negedge sys_clk);
    chk(irq, 1'b0);
    drain();
  endtask : t_overrun
  task automatic t_cutoff();
    wr(CSSIO_CTRL_OFF, 32'h51);
    @(negedge sys_clk);
    chk({serial_out_oe, ready_to_accept_oe, third_shift_clock_pin_oe}, 3'h7);
    @(posedge sys_clk);
    shutdown_in <= 1'b0;
    repeat (5) @(negedge sys_clk);
    chk({serial_out_oe, ready_to_accept_oe, third_shift_clock_pin_oe}, 3'h0);
    @(posedge sys_clk);
    shutdown_in <= 1'b1;
    wr(CSSIO_CTRL_OFF, 32'h00);
  endtask : t_cutoff
  task automatic t_unmapped();
    rd(8'h1C);
    chk({rsp, rdat}, {2'h2, 32'h0});
    wr(8'h20, 32'h5);
    chk(rsp, 2'h2);
  endtask : t_unmapped
  initial begin
    arst_n = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    s_axi_wstrb = 4'hF;
    send_permit_in = 1'b0;
    shutdown_in = 1'b1;
    edge_sel = 1'b0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_internal(1'b1);
    t_internal(1'b0);
    t_start();
    t_external();
    t_overrun();
    t_cutoff();
    t_unmapped();
    end_of_test();
  end
  // whole run is about ten microseconds
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
endmodule : clock_sync_serial_io_tb_top
`default_nettype wire
